// ===== osd_display_timing_ram_port.v
// overlay display timing generator and display ram write port
// assumes a pixel clock as i_ref_clk, sync pins asynchronous, wishbone master
//
// Our own choices: the Wishbone register port and the register offsets.
`include "osd_timing_consts.vh"
`default_nettype none

module osd_display_timing_ram_port #(
    parameter HCNT_W = 12,
    parameter VCNT_W = 12
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_srst,
    // wishbone slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [5:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // sync inputs
    input wire i_overlay_hsync_in,
    input wire i_overlay_vsync_in,
    // display timing outputs
    output reg o_h_active,
    output reg o_v_active,
    output reg [4:0] o_cell_col,
    output reg [3:0] o_cell_row,
    output reg [4:0] o_font_line,
    output reg [8:0] o_font_index,
    output reg [6:0] o_attribute,
    output reg o_char_visible,
    output reg o_row_intensity
);

// ----------------------------------------------------------------
// registers and memories
// ----------------------------------------------------------------
reg [7:0] row_ptr_r;
reg [4:0] col_ptr_r;
reg [7:0] vdelay_r;
reg [7:0] hdelay_r;
reg [6:0] char_height_r;
reg global_double_width_r;
reg [8:0] addr_mem [0:511];
reg [7:0] attr_mem [0:511];
reg [2:0] row_ctrl_r [0:15];
reg [8:0] rd_word_r;
integer k;

// synchronisers
reg [1:0] hs_sync_r;
reg [1:0] vs_sync_r;
reg hs_prev_r;
reg vs_prev_r;
wire hs_lead = hs_sync_r[1] & ~hs_prev_r;
wire vs_lead = vs_sync_r[1] & ~vs_prev_r;

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function [6:0] line_weight;
    input [6:0] ch;
    begin
        case (ch[6:5])
            2'b11: line_weight = `W_HI11;
            2'b10: line_weight = `W_HI10;
            default: line_weight = `W_HI0X;
        endcase
        line_weight = line_weight + {2'b00, ch[4:0]};
    end
endfunction

// number of extra repeats of a font line
function [2:0] repeats;
    input [6:0] ch;
    input [4:0] ln;
    reg [2:0] n;
    begin
        n = 3'd0;
        if (ch[6]) begin
            n = n + 3'd1;
        end
        if (ch[6] && ch[5]) begin
            n = n + 3'd1;
        end
        if (ch[4] && ln >= 5'd1 && ln <= 5'd16) begin
            n = n + 3'd1;
        end
        if (ch[3] && ln[0] && ln <= 5'd15) begin
            n = n + 3'd1;
        end
        if (ch[2] && (ln == 5'd2 || ln == 5'd6 || ln == 5'd10 || ln == 5'd14)) begin
            n = n + 3'd1;
        end
        if (ch[1] && (ln == 5'd4 || ln == 5'd12)) begin
            n = n + 3'd1;
        end
        if (ch[0] && ln == 5'd8) begin
            n = n + 3'd1;
        end
        repeats = n;
    end
endfunction

function [8:0] ram_index;
    input [3:0] r;
    input [4:0] c;
    begin
        ram_index = {r, c};
    end
endfunction

// ----------------------------------------------------------------
// wishbone slave with display ram write port
// ----------------------------------------------------------------
wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
wire bus_wr = bus_req & i_wb_we & i_wb_sel[0];
wire data_wr = bus_wr & (i_wb_adr == `ADR_DATA_LO || i_wb_adr == `ADR_DATA_HI);
wire [8:0] wr_idx = ram_index(row_ptr_r[3:0], col_ptr_r);
wire [8:0] wr_word = {(i_wb_adr == `ADR_DATA_HI), i_wb_dat[7:0]};

always @(posedge i_ref_clk) begin
    if (data_wr) begin
        if (row_ptr_r[7:6] == `PLANE_ADDR) begin
            addr_mem[wr_idx] <= wr_word;
        end else if (row_ptr_r[7:6] == `PLANE_ATTR) begin
            attr_mem[wr_idx] <= wr_word[7:0];
        end
    end
    rd_word_r <= addr_mem[wr_idx];
end

always @(posedge i_ref_clk) begin
    if (i_srst) begin
        o_wb_ack <= 1'b0;
        o_wb_dat <= 32'h0000_0000;
        row_ptr_r <= 8'h00;
        col_ptr_r <= 5'h00;
        vdelay_r <= 8'h00;
        hdelay_r <= 8'h00;
        char_height_r <= 7'h00;
        global_double_width_r <= 1'b0;
        for (k = 0; k < 16; k = k + 1) begin
            row_ctrl_r[k] <= 3'h0;
        end
    end else begin
        o_wb_ack <= bus_req;
        o_wb_dat <= 32'h0000_0000;
        if (bus_req && !i_wb_we) begin
            case (i_wb_adr)
                `ADR_VDELAY: o_wb_dat <= {24'h000000, vdelay_r};
                `ADR_HDELAY: o_wb_dat <= {24'h000000, hdelay_r};
                `ADR_CHAR_HEIGHT: o_wb_dat <= {25'h0000000, char_height_r};
                `ADR_CONTROL: o_wb_dat <= {31'h00000000, global_double_width_r};
                `ADR_STATUS: o_wb_dat <= {14'h0000, o_v_active, o_h_active,
                                          row_ptr_r, 3'h0, col_ptr_r};
                `ADR_READ_DATA: o_wb_dat <= {23'h000000, rd_word_r};
                default: o_wb_dat <= 32'h0000_0000;
            endcase
        end
        if (bus_wr) begin
            case (i_wb_adr)
                `ADR_ROW_PTR: row_ptr_r <= i_wb_dat[7:0];
                `ADR_COL_PTR: col_ptr_r <= i_wb_dat[4:0];
                `ADR_VDELAY: vdelay_r <= i_wb_dat[7:0];
                `ADR_HDELAY: hdelay_r <= i_wb_dat[7:0];
                `ADR_CHAR_HEIGHT: char_height_r <= i_wb_dat[6:0];
                `ADR_CONTROL: global_double_width_r <= i_wb_dat[0];
                default: ;
            endcase
        end
        if (data_wr) begin
            if (row_ptr_r[7:6] == `PLANE_ADDR && col_ptr_r == `ROW_CTRL_COL) begin
                row_ctrl_r[row_ptr_r[3:0]] <= i_wb_dat[2:0];
            end
            col_ptr_r <= col_ptr_r + 5'd1;
            if (col_ptr_r == 5'h1f) begin
                row_ptr_r[3:0] <= row_ptr_r[3:0] + 4'd1;
            end
        end
    end
end

// ----------------------------------------------------------------
// horizontal timing
// ----------------------------------------------------------------
reg [HCNT_W-1:0] hcnt_r;
reg hrun_r;
reg [8:0] hdot_r;
reg [3:0] cell_dot_r;
wire [31:0] h_start_full = hdelay_r * `H_MUL + `H_OFS;
wire [HCNT_W-1:0] h_start = h_start_full[HCNT_W-1:0];

always @(posedge i_ref_clk) begin
    if (i_srst) begin
        hs_sync_r <= 2'b00;
        vs_sync_r <= 2'b00;
        hs_prev_r <= 1'b0;
        vs_prev_r <= 1'b0;
        hcnt_r <= {HCNT_W{1'b0}};
        hrun_r <= 1'b0;
        hdot_r <= 9'd0;
        cell_dot_r <= 4'd0;
        o_h_active <= 1'b0;
        o_cell_col <= 5'd0;
    end else begin
        hs_sync_r <= {hs_sync_r[0], i_overlay_hsync_in};
        vs_sync_r <= {vs_sync_r[0], i_overlay_vsync_in};
        hs_prev_r <= hs_sync_r[1];
        vs_prev_r <= vs_sync_r[1];
        if (hs_lead) begin
            hcnt_r <= {HCNT_W{1'b0}};
            hrun_r <= 1'b1;
            o_h_active <= 1'b0;
        end else if (hrun_r) begin
            hcnt_r <= hcnt_r + 1'b1;
            if (hcnt_r + 1'b1 == h_start) begin
                hrun_r <= 1'b0;
                o_h_active <= 1'b1;
                hdot_r <= 9'd0;
                cell_dot_r <= 4'd0;
                o_cell_col <= 5'd0;
            end
        end else if (o_h_active) begin
            hdot_r <= hdot_r + 9'd1;
            if (hdot_r == `ACTIVE_DOTS - 9'd1) begin
                o_h_active <= 1'b0; // rest of line blank
            end
            if (cell_dot_r == `CELL_DOTS - 4'd1) begin
                cell_dot_r <= 4'd0;
                o_cell_col <= o_cell_col + 5'd1;
            end else begin
                cell_dot_r <= cell_dot_r + 4'd1;
            end
        end
    end
end

// ----------------------------------------------------------------
// vertical timing with line repeat
// ----------------------------------------------------------------
reg [VCNT_W-1:0] vcnt_r;
reg vrun_r;
reg [2:0] rep_r;
reg dbl_phase_r;
wire [31:0] v_start_full = vdelay_r * `V_MUL + `V_OFS;
wire [VCNT_W-1:0] v_start = v_start_full[VCNT_W-1:0];
wire [2:0] row_ctrl = row_ctrl_r[o_cell_row];
wire [2:0] line_reps = repeats(char_height_r, o_font_line);
wire [6:0] height_now = line_weight(char_height_r);

always @(posedge i_ref_clk) begin
    if (i_srst) begin
        vcnt_r <= {VCNT_W{1'b0}};
        vrun_r <= 1'b0;
        rep_r <= 3'd0;
        dbl_phase_r <= 1'b0;
        o_v_active <= 1'b0;
        o_cell_row <= 4'd0;
        o_font_line <= 5'd0;
    end else if (vs_lead) begin
        vcnt_r <= {VCNT_W{1'b0}};
        vrun_r <= 1'b1;
        o_v_active <= 1'b0;
    end else if (hs_lead) begin
        if (vrun_r) begin
            vcnt_r <= vcnt_r + 1'b1;
            if (vcnt_r + 1'b1 == v_start) begin
                vrun_r <= 1'b0;
                o_v_active <= 1'b1;
                o_cell_row <= 4'd0;
                o_font_line <= 5'd0;
                rep_r <= 3'd0;
                dbl_phase_r <= 1'b0;
            end
        end else if (o_v_active) begin
            // each displayed line: base, then repeats, all doubled on tall rows
            if (row_ctrl[`BIT_DBL_HEIGHT] && !dbl_phase_r) begin
                dbl_phase_r <= 1'b1;
            end else if (rep_r < line_reps) begin
                dbl_phase_r <= 1'b0;
                rep_r <= rep_r + 3'd1;
            end else begin
                dbl_phase_r <= 1'b0;
                rep_r <= 3'd0;
                if (o_font_line == `FONT_LINES - 5'd1) begin
                    o_font_line <= 5'd0;
                    if (o_cell_row == `LAST_ROW) begin
                        o_v_active <= 1'b0;
                    end else begin
                        o_cell_row <= o_cell_row + 4'd1;
                    end
                end else begin
                    o_font_line <= o_font_line + 5'd1;
                end
            end
        end
    end
end

// ----------------------------------------------------------------
// character fetch for the current cell
// ----------------------------------------------------------------
wire [8:0] rd_idx = ram_index(o_cell_row, o_cell_col);
wire wide = row_ctrl[`BIT_DBL_WIDTH] | global_double_width_r;

always @(posedge i_ref_clk) begin
    if (i_srst) begin
        o_font_index <= 9'd0;
        o_attribute <= 7'd0;
        o_char_visible <= 1'b0;
        o_row_intensity <= 1'b0;
    end else begin
        o_font_index <= addr_mem[rd_idx];
        o_attribute <= attr_mem[rd_idx][6:0];
        o_row_intensity <= row_ctrl[`BIT_INTENSITY];
        o_char_visible <= o_h_active & o_v_active & (o_cell_col <= `LAST_COL)
                          & ~(wide & o_cell_col[0])
                          & (height_now != 7'd0);
    end
end

endmodule // osd_display_timing_ram_port

`default_nettype wire

// ===== osd_timing_consts.vh
// constants for the overlay display timing and display ram write port
// assumes a 50 MHz clock and a classic wishbone register bus
`ifndef OSD_TIMING_CONSTS_VH
`define OSD_TIMING_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADR_ROW_PTR 6'h00
`define ADR_COL_PTR 6'h04
`define ADR_DATA_LO 6'h08
`define ADR_DATA_HI 6'h0c
`define ADR_VDELAY 6'h10
`define ADR_HDELAY 6'h14
`define ADR_CHAR_HEIGHT 6'h18
`define ADR_CONTROL 6'h1c
`define ADR_STATUS 6'h20
`define ADR_READ_DATA 6'h24

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define PLANE_ADDR 2'h0
`define PLANE_ATTR 2'h1
`define ROW_CTRL_COL 5'h1e
`define LAST_ROW 4'he
`define LAST_COL 5'h1d
`define BIT_INTENSITY 2
`define BIT_DBL_HEIGHT 1
`define BIT_DBL_WIDTH 0

// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define ACTIVE_DOTS 9'd360
`define CELL_DOTS 4'd12
`define FONT_LINES 5'd18
`define H_MUL 6
`define H_OFS 49
`define V_MUL 4
`define V_OFS 1
`define W_HI11 7'd54
`define W_HI10 7'd36
`define W_HI0X 7'd18

`endif

// ===== osd_cpu_model.sv
// bus-master model of the embedded processor that fills the display ram
// assumes classic wishbone, one request at a time, registered ack
`default_nettype none
module osd_cpu_model (
    // clock
    input wire logic i_ref_clk,
    // wishbone master side
    output logic o_cyc,
    output logic o_stb,
    output logic o_we,
    output logic [5:0] o_adr,
    output logic [3:0] o_sel,
    output logic [31:0] o_dat,
    // slave answer
    input wire logic i_ack,
    input wire logic [31:0] i_rdat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] q;
    initial begin
        {o_cyc, o_stb, o_we, o_adr, o_dat} = '0;
        o_sel = 4'h1;
    end
    // request held until ack is sampled, then one idle cycle
    task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        {o_cyc, o_stb, o_we, o_adr, o_dat} <= {2'h3, w, a, 24'h0, d};
        do @(posedge i_ref_clk); while (i_ack !== 1'b1);
        q = i_rdat;
        {o_cyc, o_stb} <= 2'h0;
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task rd(input logic [5:0] a, output logic [31:0] v);
        xfer(1'b0, a, 8'h0);
        v = q;
    endtask
endmodule // osd_cpu_model
`default_nettype wire

// ===== osd_display_timing_ram_port_sva.sv
// assertions on the register bus and the active line window
// assumes binding to the block, seeing only its ports
`default_nettype none
module osd_display_timing_ram_port_sva (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [5:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_h_active,
    input wire logic o_v_active,
    input wire logic [4:0] o_cell_col,
    input wire logic o_char_visible
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] hrun_r;
    wire logic req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic rd_ack = o_wb_ack && !i_wb_we;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // dots counted while the line window is open
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !o_h_active) begin
            hrun_r <= 10'h0;
        end else begin
            hrun_r <= hrun_r + 10'h1;
        end
    end
    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack stood longer than one cycle");
    chk_ack_latency: assert property (req |=> o_wb_ack)
        else $error("ack missing one cycle after request");
    chk_ack_cause: assert property (o_wb_ack |-> $past(req))
        else $error("ack without a request");
    chk_rdat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data not zero outside ack");
    chk_wo_reads_zero: assert property (rd_ack && i_wb_adr <= 6'h0c |-> o_wb_dat == 32'h0)
        else $error("write-only register read nonzero");
    chk_status_upper: assert property (rd_ack && i_wb_adr == 6'h20 |-> o_wb_dat[31:18] == 14'h0)
        else $error("status upper bits nonzero");
    chk_unmapped_zero: assert property (rd_ack && i_wb_adr > 6'h24 |-> o_wb_dat == 32'h0)
        else $error("unmapped read nonzero");
    chk_hactive_width: assert property ($fell(o_h_active) |-> hrun_r == 10'd360)
        else $error("line window not 360 dots");
    chk_hactive_hold: assert property ($rose(o_h_active) |=> o_h_active [*8])
        else $error("line window closed early");
    chk_visible_window: assert property (o_char_visible |-> $past(o_h_active) && $past(o_v_active))
        else $error("cell shown outside display window");
    chk_visible_cols: assert property (o_char_visible |-> $past(o_cell_col) <= 5'd29)
        else $error("cell shown beyond last column");
endmodule // osd_display_timing_ram_port_sva
`default_nettype wire

// ===== osd_display_timing_ram_port_tb.sv
// self-checking bench for the overlay timing block and display ram port
// assumes the cpu bus model and the checker are compiled first
`default_nettype none
module osd_display_timing_ram_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_srst, hs, vs, ack, hact, vact, cyc, stb, we, h;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [7:0] r, c, d;
    logic [31:0] wdat, rdat, v;
    logic [8:0] fidx, fi0;
    logic [6:0] attr, at0;
    logic [4:0] col, fline;
    logic [3:0] row;
    logic row_intensity;
    int err_count = 0, n_tests = 0, s0, s7, l0, l7, n0, n2;
    logic [24:0] tab [4] = '{25'h0000012, 25'h0060ba5, 25'h01c3aff, 25'h01c3c07};
    osd_cpu_model cpu (.i_ref_clk(i_ref_clk), .o_cyc(cyc), .o_stb(stb), .o_we(we),
        .o_adr(adr), .o_sel(sel), .o_dat(wdat), .i_ack(ack), .i_rdat(rdat));
    osd_display_timing_ram_port DUT (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_overlay_hsync_in(hs),
        .i_overlay_vsync_in(vs), .o_h_active(hact), .o_v_active(vact), .o_cell_col(col),
        .o_cell_row(row), .o_font_line(fline), .o_font_index(fidx), .o_attribute(attr),
        .o_char_visible(), .o_row_intensity(row_intensity));
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task put(input logic [7:0] pr, input logic [7:0] pc, input logic [5:0] a,
             input logic [7:0] pd);
        cpu.wr(6'h00, pr);
        cpu.wr(6'h04, pc);
        cpu.wr(a, pd);
    endtask
    // one sync pulse, then where and how long the window opens
    task hline(output int st, output int ln);
        st = 0;
        ln = 0;
        @(posedge i_ref_clk) hs <= 1'b1;
        for (int k = 1; k < 480; k++) begin
            @(posedge i_ref_clk);
            if (k == 8) hs <= 1'b0;
            if (hact === 1'b1) begin
                if (ln == 0) st = k;
                if (ln == 1) begin
                    fi0 = fidx;
                    at0 = attr;
                end
                ln++;
            end
        end
    endtask
    task vmeasure(output int n);
        int s, l;
        n = 0;
        @(posedge i_ref_clk) vs <= 1'b1;
        repeat (20) begin
            hline(s, l);
            vs <= 1'b0;
            if (vact !== 1'b1) n++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_ref_clk);
        err_count++;
        report_and_stop;
    end
    initial begin
        {hs, vs, i_srst} = 3'h1;
        repeat (12) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {r, c, h, d} = tab[i];
            put(r, c, h ? 6'h0c : 6'h08, d);
            cpu.rd(6'h20, v);
            chk(v[15:0], {r, 3'h0, c[4:0] + 5'h1});
            cpu.wr(6'h04, c);
            cpu.rd(6'h24, v);
            chk(v[15:0], {7'h0, h, d});
        end
        put(8'h05, 8'h1f, 6'h08, 8'h33);
        cpu.rd(6'h20, v);
        chk(v[15:0], 16'h0600);
        put(8'h0f, 8'h1f, 6'h08, 8'h33);
        cpu.rd(6'h20, v);
        chk(v[15:0], 16'h0000);
        put(8'h40, 8'h00, 6'h0c, 8'h55);
        put(8'h02, 8'h00, 6'h0c, 8'h21);
        cpu.wr(6'h08, 8'h22);
        cpu.wr(6'h04, 8'h01);
        cpu.rd(6'h24, v);
        chk(v[15:0], 16'h0022);
        put(8'h00, 8'h00, 6'h04, 8'h00);
        cpu.rd(6'h24, v);
        chk(v[15:0], 16'h0012);
        cpu.rd(6'h00, v);
        chk(v[15:0], 16'h0000);
        cpu.rd(6'h30, v);
        chk(v[15:0], 16'h0000);
        cpu.wr(6'h14, 8'h00);
        hline(s0, l0);
        chk({7'h0, fi0}, 16'h0012);
        chk({9'h0, at0}, 16'h0055);
        cpu.wr(6'h14, 8'h07);
        hline(s7, l7);
        chk({11'h0, col}, 16'd30);
        chk(16'(l0), 16'd360);
        chk(16'(s7 - s0), 16'd42);
        cpu.wr(6'h10, 8'h02);
        vmeasure(n2);
        i_srst <= 1'b1;
        @(posedge i_ref_clk);
        i_srst <= 1'b0;
        cpu.rd(6'h20, v);
        chk(v[15:0], 16'h0000);
        put(8'h01, 8'h1e, 6'h08, 8'h04);
        vmeasure(n0);
        chk({7'h0, row, fline}, 16'h0021);
        chk({15'h0, row_intensity}, 16'h0001);
        chk(16'(n2 - n0), 16'd8);
        report_and_stop;
    end
endmodule // osd_display_timing_ram_port_tb
bind osd_display_timing_ram_port osd_display_timing_ram_port_sva chk_u (.i_ref_clk,
    .i_srst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_h_active,
    .o_v_active, .o_cell_col, .o_char_visible);
`default_nettype wire
